// ===== rtl/twfc_params.svh
// Purpose: named constants for the typewriter format control block
// Assumes: included by the package and by the top module
// Notes: character code is {x, o, 8, 4, 2, 1}
`ifndef TWFC_PARAMS_SVH
`define TWFC_PARAMS_SVH

`define TWFC_CHAR_W 6
`define TWFC_POS_W 7
`define TWFC_SEL_N 10
`define TWFC_LAST_POS 7'h63
`define TWFC_POS_ONE 7'h01
`define TWFC_POS_ZERO 7'h00
`define TWFC_XBIT 5
`define TWFC_NUM_MASK 6'h0f
`define TWFC_ZERO_CHAR 6'h0a
`define TWFC_ADR_W 4
`define TWFC_REG_CMD 4'h0
`define TWFC_REG_SEL 4'h4
`define TWFC_REG_STAT 4'h8
`define TWFC_CTL_W 24
`define TWFC_DROP_LSB 16
`define TWFC_FIFO_DEPTH 2'h2

`endif

// ===== rtl/twfc_pkg.sv
// Purpose: types shared by the typewriter format control block
// Assumes: twfc_params.svh supplies widths
// Notes: control struct layout is also the command register layout
`include "twfc_params.svh"
package twfc_pkg;

  typedef enum logic [2:0] {
    TWFC_IDLE  = 3'b000,
    TWFC_CC    = 3'b001,
    TWFC_DELAY = 3'b010,
    TWFC_SPLIT = 3'b011,
    TWFC_TALL  = 3'b100
  } twfc_state_t;

  // [23] zb_set ... [0] fixed_char lsb
  typedef struct packed {
    logic zb_set;
    logic zb_clear;
    logic type_all;
    logic col_split;
    logic cc_delay;
    logic rib_black;
    logic rib_red;
    logic clear;
    logic cc_on;
    logic cc_entry;
    logic fixed_req;
    logic [`TWFC_POS_W-1:0] entry_pos;
    logic [`TWFC_CHAR_W-1:0] fixed_char;
  } twfc_ctl_t;

  typedef struct packed {
    logic red;
    logic [`TWFC_CHAR_W-1:0] chr;
  } twfc_typ_t;

endpackage

// ===== rtl/twfc_top.sv
// Purpose: format control between track stream, plugboard strobes and typewriter
// Assumes: one track character offered per cycle; plugboard strobes on i_clk
// Notes: wishbone classic slave, one wait state, ack one cycle
//
// What this block does
// R1 - zero under blanking skipped, skip pulse instead
// R2 - blank-off strobe or nonzero character ends blanking
// R3 - wiring sets blanking one position early
// R4 - blank-off acts in its own position
// R5 - type-all types 100 positions, ignores controls
// R6 - split tests x-bit, suspends next cycle
// R7 - x pulse if x-bit, else no-x pulse
// R8 - split from column exit prints numeric only
// R9 - wiring never splits with column entry
// R10 - ribbon change applies from next character
// R11 - clear leaves ribbon colour alone
// R12 - fixed entry types its assigned character
// R13 - delay request suspends one cycle, pulses
// R14 - clear drops selectors, position to zero
// R15 - format key start only when inquiry allowed
// R16 - after delay resume at following step
// R17 - selector picks to transfer, stays until drop
// R18 - one position per cycle unless suspended
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/10ps
`include "twfc_params.svh"
module twfc_top
  import twfc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [`TWFC_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire twfc_ctl_t i_ctl,
  input wire logic [`TWFC_SEL_N-1:0] i_sel_pick,
  input wire logic [`TWFC_SEL_N-1:0] i_sel_drop,
  input wire logic i_trk_valid,
  input wire logic [`TWFC_CHAR_W-1:0] i_trk_char,
  output logic o_trk_ready,
  output logic [`TWFC_POS_W-1:0] o_pos,
  output logic o_typ_valid,
  output twfc_typ_t o_typ_data,
  input wire logic i_typ_ready,
  output logic o_zero_skip_pulse,
  output logic o_delay_cycle_pulse,
  output logic o_zone_bit_out,
  output logic o_no_zone_bit_out,
  output logic [`TWFC_SEL_N-1:0] o_sel,
  input wire logic i_fmt_key,
  input wire logic i_inquiry_ok,
  output logic o_fmt_start
);

  function automatic logic is_zero(input logic [`TWFC_CHAR_W-1:0] c);
    is_zero = (c == `TWFC_ZERO_CHAR);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic wr_ok, wr_cmd, wr_sel;
  twfc_ctl_t ctl;
  twfc_state_t st_ff, nxt_st;
  logic [`TWFC_POS_W-1:0] pos_ff, nxt_pos;
  logic zb_ff, nxt_zb;
  logic red_ff, nxt_red;
  logic [`TWFC_SEL_N-1:0] sel_ff, nxt_sel;

  // write lands at the edge where ack is sampled high
  assign wr_ok = i_wb_cyc && i_wb_stb && i_wb_we && ack_ff && i_ce;
  assign wr_cmd = wr_ok && (i_wb_adr == `TWFC_REG_CMD) && (&i_wb_sel[2:0]);
  assign wr_sel = wr_ok && (i_wb_adr == `TWFC_REG_SEL);
  assign ctl = wr_cmd ? (i_ctl | twfc_ctl_t'(i_wb_dat[`TWFC_CTL_W-1:0])) : i_ctl;

  always_comb begin
    nxt_ack = i_wb_cyc && i_wb_stb && !ack_ff;
    nxt_rdat = 32'h0;
    if (i_wb_adr == `TWFC_REG_SEL) begin
      nxt_rdat[`TWFC_SEL_N-1:0] = sel_ff;
    end else if (i_wb_adr == `TWFC_REG_STAT) begin
      nxt_rdat = {20'h0, st_ff, zb_ff, red_ff, pos_ff};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end else if (i_ce) begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdat_ff;

  //////////////////////////////////////////////////////////////////////////////
  // two-entry output buffer; a typewriter stall holds the track back
  twfc_typ_t mem_ff [2];
  twfc_typ_t push_data;
  logic push, pop, room;
  logic wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [1:0] cnt_ff, nxt_cnt;

  assign room = (cnt_ff != `TWFC_FIFO_DEPTH);
  assign pop = i_ce && (cnt_ff != 2'h0) && i_typ_ready;
  assign o_typ_valid = (cnt_ff != 2'h0);
  assign o_typ_data = mem_ff[rd_ff];

  always_comb begin
    nxt_wr = wr_ff ^ push;
    nxt_rd = rd_ff ^ pop;
    nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else if (i_ce) begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
      if (push) begin
        mem_ff[wr_ff] <= push_data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // format sequencer
  logic fixed_take, step, live;
  logic skip_ff, nxt_skip, dly_ff, nxt_dly, x_ff, nxt_x, nx_ff, nxt_nx;

  // type-all makes every other control strobe dead; selector picks and drops still act
  assign live = (st_ff != TWFC_TALL);
  assign fixed_take = i_ce && live && ctl.fixed_req && room; // R12
  assign step = i_ce && i_trk_valid && room && !fixed_take &&
                (st_ff == TWFC_CC || st_ff == TWFC_TALL); // R18
  assign o_trk_ready = step;
  assign o_pos = pos_ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_pos = pos_ff;
    nxt_zb = zb_ff;
    nxt_red = red_ff;
    nxt_skip = 1'b0;
    nxt_dly = 1'b0;
    nxt_x = 1'b0;
    nxt_nx = 1'b0;
    push = 1'b0;
    push_data = '{red: red_ff, chr: i_trk_char};
    if (fixed_take) begin
      push = 1'b1; // R12
      push_data.chr = ctl.fixed_char;
    end
    if (st_ff == TWFC_TALL) begin
      if (step) begin
        push = 1'b1; // R5
        if (pos_ff == `TWFC_LAST_POS) begin
          nxt_pos = `TWFC_POS_ZERO;
          nxt_st = TWFC_IDLE;
        end else begin
          nxt_pos = pos_ff + `TWFC_POS_ONE;
        end
      end
    end else if (i_ce) begin
      case (st_ff)
        TWFC_DELAY, TWFC_SPLIT: begin
          // position already moved on when the suspension was requested
          nxt_st = TWFC_CC; // R16
        end
        TWFC_CC: begin
          if (step) begin
            nxt_pos = (pos_ff == `TWFC_LAST_POS) ? `TWFC_POS_ZERO : pos_ff + `TWFC_POS_ONE; // R18
            if (zb_ff && !ctl.zb_clear && is_zero(i_trk_char)) begin
              nxt_skip = 1'b1; // R1
            end else begin
              push = 1'b1; // R4
              nxt_zb = 1'b0; // R2
              if (ctl.col_split) begin
                push_data.chr = i_trk_char & `TWFC_NUM_MASK; // R8
              end
            end
            if (ctl.col_split) begin
              nxt_st = TWFC_SPLIT; // R6
              nxt_x = i_trk_char[`TWFC_XBIT]; // R7
              nxt_nx = !i_trk_char[`TWFC_XBIT]; // R7
            end else if (ctl.cc_delay) begin
              nxt_st = TWFC_DELAY; // R13
              nxt_dly = 1'b1; // R13
            end
          end
        end
        default: begin
          nxt_st = st_ff;
        end
      endcase
      // blank-off in its own position, blank-on counts from the next one
      if (ctl.zb_clear) begin
        nxt_zb = 1'b0; // R2
      end
      if (ctl.zb_set) begin
        nxt_zb = 1'b1;
      end
      if (ctl.rib_red) begin
        nxt_red = 1'b1; // R10
      end else if (ctl.rib_black) begin
        nxt_red = 1'b0; // R10
      end
      if (ctl.cc_entry) begin
        nxt_pos = ctl.entry_pos;
        nxt_st = TWFC_CC;
      end else if (ctl.cc_on && st_ff == TWFC_IDLE) begin
        nxt_st = TWFC_CC;
      end
      // a clearing column still types first; ribbon is untouched
      if (ctl.clear) begin
        nxt_st = TWFC_IDLE; // R14
        nxt_pos = `TWFC_POS_ZERO; // R14
        nxt_zb = 1'b0;
      end
      if (ctl.type_all) begin
        nxt_st = TWFC_TALL; // R5
        nxt_pos = `TWFC_POS_ZERO;
        nxt_zb = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_ff <= TWFC_IDLE;
      pos_ff <= `TWFC_POS_ZERO;
      zb_ff <= 1'b0;
      red_ff <= 1'b0;
      skip_ff <= 1'b0;
      dly_ff <= 1'b0;
      x_ff <= 1'b0;
      nx_ff <= 1'b0;
    end else if (i_ce) begin
      st_ff <= nxt_st;
      pos_ff <= nxt_pos;
      zb_ff <= nxt_zb;
      red_ff <= nxt_red; // R11
      skip_ff <= nxt_skip;
      dly_ff <= nxt_dly;
      x_ff <= nxt_x;
      nx_ff <= nxt_nx;
    end
  end

  assign o_zero_skip_pulse = skip_ff;
  assign o_delay_cycle_pulse = dly_ff;
  assign o_zone_bit_out = x_ff;
  assign o_no_zone_bit_out = nx_ff;

  //////////////////////////////////////////////////////////////////////////////
  // selectors: pick wins over drop, clear drops all
  genvar gi;
  generate
    for (gi = 0; gi < `TWFC_SEL_N; gi++) begin : g_sel
      logic pk, dr;
      assign pk = i_sel_pick[gi] || (wr_sel && i_wb_dat[gi]);
      assign dr = i_sel_drop[gi] || (wr_sel && i_wb_dat[`TWFC_DROP_LSB + gi]) ||
                  (ctl.clear && live);
      assign nxt_sel[gi] = pk ? 1'b1 : (dr ? 1'b0 : sel_ff[gi]); // R17
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sel_ff <= '0;
    end else if (i_ce) begin
      sel_ff <= nxt_sel; // R14
    end
  end

  assign o_sel = sel_ff;

  //////////////////////////////////////////////////////////////////////////////
  // format key: three-stage synchroniser, start waits for inquiry window
  logic [2:0] key_sync_ff, nxt_key_sync;
  logic key_lvl_ff, nxt_key_lvl, pend_ff, nxt_pend, start_ff, nxt_start;

  always_comb begin
    nxt_key_sync = {key_sync_ff[1:0], i_fmt_key};
    nxt_key_lvl = (key_sync_ff[1] == key_sync_ff[2]) ? key_sync_ff[2] : key_lvl_ff;
    nxt_start = pend_ff && i_inquiry_ok; // R15
    nxt_pend = (pend_ff && !nxt_start) || (nxt_key_lvl && !key_lvl_ff);
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      key_sync_ff <= 3'h0;
      key_lvl_ff <= 1'b0;
      pend_ff <= 1'b0;
      start_ff <= 1'b0;
    end else if (i_ce) begin
      key_sync_ff <= nxt_key_sync;
      key_lvl_ff <= nxt_key_lvl;
      pend_ff <= nxt_pend;
      start_ff <= nxt_start;
    end
  end

  assign o_fmt_start = start_ff;

  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n || !i_ce);

  a_zero_skipped: assert property ((step && st_ff == TWFC_CC && zb_ff && !ctl.zb_clear && // R1
    is_zero(i_trk_char)) |-> !push ##1 o_zero_skip_pulse) else $error("zero not skipped");
  a_blank_ends: assert property ((step && st_ff == TWFC_CC && !is_zero(i_trk_char) && // R2
    !ctl.zb_set) |=> !zb_ff) else $error("blanking kept after nonzero");
  a_blank_off_now: assert property ((step && st_ff == TWFC_CC && ctl.zb_clear) |-> push) // R4
    else $error("blank-off not effective in its position");
  a_type_all_raw: assert property ((step && st_ff == TWFC_TALL) |-> // R5
    push && push_data.chr == i_trk_char) else $error("type-all char altered");
  a_split_outcome: assert property ((step && st_ff == TWFC_CC && ctl.col_split) |=> // R7
    (st_ff == TWFC_SPLIT || $past(ctl.clear || ctl.type_all || ctl.cc_entry)) &&
    o_zone_bit_out == $past(i_trk_char[`TWFC_XBIT]) &&
    o_no_zone_bit_out != o_zone_bit_out) else $error("split outcome wrong");
  a_split_numeric: assert property ((step && st_ff == TWFC_CC && ctl.col_split && push) |-> // R8
    push_data.chr == (i_trk_char & `TWFC_NUM_MASK)) else $error("zone not dropped");
  a_ribbon_next: assert property ((push && ctl.rib_red && !red_ff) |-> // R10
    !push_data.red ##1 (red_ff || !$past(live))) else $error("ribbon change not deferred");
  a_clear_ribbon: assert property ((ctl.clear && !ctl.rib_red && !ctl.rib_black) |=> // R11
    red_ff == $past(red_ff)) else $error("clear changed ribbon");
  a_delay_one: assert property ((step && st_ff == TWFC_CC && ctl.cc_delay && // R13
    !ctl.col_split && !ctl.clear && !ctl.type_all && !ctl.cc_entry) |=>
    o_delay_cycle_pulse && st_ff == TWFC_DELAY && !o_trk_ready ##1 st_ff == TWFC_CC)
    else $error("delay cycle wrong");
  a_clear_all: assert property ((ctl.clear && live && !ctl.type_all) |=> // R14
    pos_ff == `TWFC_POS_ZERO && sel_ff == '0 && st_ff == TWFC_IDLE)
    else $error("clear incomplete");
  a_fmt_gate: assert property (o_fmt_start |-> $past(i_inquiry_ok)) // R15
    else $error("start without inquiry window");
  a_step_adv: assert property ((step && st_ff == TWFC_CC && pos_ff != `TWFC_LAST_POS && // R18
    !ctl.clear && !ctl.cc_entry && !ctl.type_all) |=> pos_ff == $past(pos_ff) + `TWFC_POS_ONE)
    else $error("position did not advance");

endmodule // twfc_top

// ===== bench/twfc_partner.sv
// Purpose: typewriter mechanism and plugboard wiring around the format control
// Assumes: column exits follow the position while stepping
// Notes: wiring is muted on suspended cycles, else an exit would fire twice
`timescale 1ns/10ps
`include "twfc_params.svh"
module twfc_partner
  import twfc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic [`TWFC_POS_W-1:0] i_pos,
  input wire logic i_hold,
  input wire twfc_ctl_t i_ctl_tb,
  output twfc_ctl_t o_ctl,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire twfc_typ_t i_data,
  output logic o_ready,
  output logic o_got,
  output twfc_typ_t o_got_data
);
  twfc_ctl_t wire_ctl;
  always_comb begin
    wire_ctl = '0;
    if (i_en && !i_hold) begin
      case (i_pos)
        7'h04: wire_ctl.cc_delay = 1'b1;
        7'h07: wire_ctl.col_split = 1'b1;
        7'h09: wire_ctl.zb_set = 1'b1;
        7'h0e: wire_ctl.rib_red = 1'b1;
        7'h11: wire_ctl.zb_clear = 1'b1;
        7'h14: wire_ctl.clear = 1'b1;
        default: wire_ctl = '0;
      endcase
    end
    o_ctl = wire_ctl | i_ctl_tb;
  end
  // a stalled mechanism is what fills the two-entry buffer
  assign o_ready = !i_stall;
  always_ff @(posedge i_clk) begin
    o_got <= i_valid && o_ready;
    o_got_data <= i_data;
  end
endmodule // twfc_partner

// ===== bench/twfc_top_tb.sv
// Purpose: self-checking bench for the typewriter format control
// Assumes: partner holds the wiring and the typewriter
// Notes: column runs keep the typewriter ready; the type-all run stalls it at random
`timescale 1ns/10ps
`include "twfc_params.svh"
module twfc_top_tb
  import twfc_pkg::*;
;
  logic clk, rst_n, cyc, stb, we, ack, fmt_key, inq_ok, stall, en, got, rdy;
  logic [3:0] adr, wsel;
  logic [31:0] wdat, rdat, rd;
  logic [9:0] pick, sel, drop;
  logic [5:0] trk [0:99];
  logic trk_rdy, typ_valid, skip, dly, zx, znx, fstart;
  logic [6:0] pos;
  logic [6:0] expq[$];
  twfc_ctl_t ctl_tb, ctl, c;
  twfc_typ_t typ, got_data;
  int error_cnt, n_compared, n_skip, n_start, n_x;
  twfc_top i_dut (.i_clk(clk), .i_reset_n(rst_n), .i_ce(1'b1), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(wsel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_ctl(ctl), .i_sel_pick(pick),
    .i_sel_drop(drop), .i_trk_valid(1'b1), .i_trk_char(trk[pos]),
    .o_trk_ready(trk_rdy), .o_pos(pos), .o_typ_valid(typ_valid), .o_typ_data(typ),
    .i_typ_ready(rdy), .o_zero_skip_pulse(skip), .o_delay_cycle_pulse(dly),
    .o_zone_bit_out(zx), .o_no_zone_bit_out(znx), .o_sel(sel), .i_fmt_key(fmt_key),
    .i_inquiry_ok(inq_ok), .o_fmt_start(fstart));
  twfc_partner i_partner (.i_clk(clk), .i_en(en), .i_pos(pos), .i_hold(dly | zx | znx),
    .i_ctl_tb(ctl_tb), .o_ctl(ctl), .i_stall(stall), .i_valid(typ_valid), .i_data(typ),
    .o_ready(rdy), .o_got(got), .o_got_data(got_data));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_typ(input twfc_typ_t g, input logic [6:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: typed %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    wsel <= 4'hf;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input twfc_ctl_t v);
    @(posedge clk);
    ctl_tb <= v;
    @(posedge clk);
    ctl_tb <= '0;
  endtask
  // random stalls and ignored clears only make sense while typing all
  task automatic drain(input logic rnd);
    int k;
    twfc_ctl_t v;
    k = 0;
    while (expq.size() != 0 && k < 1000) begin
      @(posedge clk);
      v = '0;
      v.clear = rnd && ($urandom % 8 == 0);
      stall <= rnd && ($urandom % 2 == 1);
      ctl_tb <= v;
      k++;
    end
    if (k >= 1000) error_cnt++;
    @(posedge clk);
    stall <= 1'b0;
    ctl_tb <= '0;
    repeat (3) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (got) cmp_typ(got_data, expq.size() ? expq.pop_front() : 7'h7f);
    if (skip) n_skip++;
    if (zx) n_x++;
    if (znx) n_x += 16;
    if (fstart) n_start++;
    if (dly) cmp_val(pos, 32'h5);
    if (dly) cmp_val(trk_rdy, 32'h0);
    if (zx) cmp_val(pos, 32'h8);
  end
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, fmt_key, inq_ok, stall, en} = '0;
    {adr, wsel, wdat, pick, drop, ctl_tb} = '0;
    {error_cnt, n_compared, n_skip, n_start, n_x} = '0;
    void'($urandom(32'h61334410));
    for (int p = 0; p < 100; p++) trk[p] = ($urandom % 63) + 1;
    for (int p = 0; p < 100; p++) if (trk[p] == 6'h0a) trk[p] = 6'h01;
    trk[7] = trk[7] | 6'h20;
    trk[10] = 6'h0a;
    trk[11] = 6'h0a;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, 4'h8, 32'h0);
    cmp_val(rd, 32'h0);
    wb(1'b0, 4'hc, 32'h0);
    cmp_val(rd, 32'h0);
    wb(1'b1, 4'h4, 32'h8);
    wb(1'b0, 4'h4, 32'h0);
    cmp_val(rd, 32'h8);
    wb(1'b1, 4'h4, 32'h00080000);
    wb(1'b0, 4'h4, 32'h0);
    cmp_val(rd, 32'h0);
    // column run: delay, split, blanking, red ribbon, clear
    for (int p = 0; p <= 20; p++) begin
      if (p != 10 && p != 11) expq.push_back({p >= 15, (p == 7) ? trk[p] & 6'h0f : trk[p]});
    end
    @(posedge clk);
    pick <= 10'h201;
    en <= 1'b1;
    @(posedge clk);
    pick <= 10'h000;
    drop <= 10'h001;
    @(posedge clk);
    drop <= 10'h000;
    cmp_val(sel, 32'h201);
    @(posedge clk);
    cmp_val(sel, 32'h200);
    c = '0;
    c.cc_on = 1'b1;
    pulse(c);
    drain(1'b0);
    cmp_val(n_skip, 32'h2);
    cmp_val(n_x, 32'h1);
    cmp_val(sel, 32'h0);
    wb(1'b0, 4'h8, 32'h0);
    cmp_val(rd, 32'h80);
    c = '0;
    c.fixed_req = 1'b1;
    c.fixed_char = 6'h15;
    expq.push_back(7'h55);
    pulse(c);
    drain(1'b0);
    c = '0;
    c.rib_black = 1'b1;
    wb(1'b1, 4'h0, {8'h00, c});
    c = '0;
    c.fixed_req = 1'b1;
    c.fixed_char = 6'h2a;
    expq.push_back(7'h2a);
    pulse(c);
    drain(1'b0);
    // entry jump with blanking set at once; blank-off wired at position 17
    trk[16] = 6'h0a;
    trk[17] = 6'h0a;
    trk[18] = 6'h0a;
    for (int p = 17; p <= 20; p++) expq.push_back({1'b0, trk[p]});
    c = '0;
    c.cc_entry = 1'b1;
    c.zb_set = 1'b1;
    c.entry_pos = 7'h10;
    pulse(c);
    drain(1'b0);
    cmp_val(n_skip, 32'h3);
    // type all with a stalling typewriter and stray clears
    en <= 1'b0;
    for (int p = 0; p < 100; p++) trk[p] = $urandom;
    for (int p = 0; p < 100; p++) expq.push_back({1'b0, trk[p]});
    c = '0;
    c.type_all = 1'b1;
    pulse(c);
    drain(1'b1);
    cmp_val(pos, 32'h0);
    fmt_key <= 1'b1;
    repeat (10) @(posedge clk);
    cmp_val(n_start, 32'h0);
    inq_ok <= 1'b1;
    repeat (5) @(posedge clk);
    cmp_val(n_start, 32'h1);
    end_of_test();
  end
endmodule // twfc_top_tb
